// file: usm_pkg.sv
/*
   Constants, register map and carrier types of the clocked serial port.
   Assumes one system clock; the whole design imports this package.
*/
package usm_pkg;

   // ==========================================================
   // Register indices on the plain register port
   localparam logic [2:0] ADDR_BAUD_CONTROL     = 3'h0;
   localparam logic [2:0] ADDR_RECEIVE_STATUS   = 3'h1;
   localparam logic [2:0] ADDR_DIVISOR_LOW      = 3'h2;
   localparam logic [2:0] ADDR_DIVISOR_HIGH     = 3'h3;
   localparam logic [2:0] ADDR_TRANSMIT_HOLDING = 3'h4;
   localparam logic [2:0] ADDR_TRANSMIT_STATUS  = 3'h5;
   localparam logic [2:0] ADDR_RECEIVE_FIFO_TOP = 3'h6;
   localparam logic [2:0] ADDR_FLAGS            = 3'h7;

   // ==========================================================
   // Field positions
   localparam int BIT_RECEIVE_IDLE      = 6;
   localparam int BIT_CLOCK_POLARITY    = 4;
   localparam int BIT_WIDE_DIVISOR      = 3;
   localparam int BIT_PORT_ENABLE       = 7;
   localparam int BIT_NINE_RECEIVE      = 6;
   localparam int BIT_SINGLE_RECEIVE    = 5;
   localparam int BIT_CONTINUOUS        = 4;
   localparam int BIT_OVERRUN           = 1;
   localparam int BIT_RECEIVE_NINTH     = 0;
   localparam int BIT_CLOCK_SOURCE      = 7;
   localparam int BIT_NINE_TRANSMIT     = 6;
   localparam int BIT_TRANSMIT_ENABLE   = 5;
   localparam int BIT_CLOCKED_MODE      = 4;
   localparam int BIT_HIGH_SPEED        = 2;
   localparam int BIT_SHIFTER_EMPTY     = 1;
   localparam int BIT_TRANSMIT_NINTH    = 0;
   localparam int BIT_RECEIVE_FLAG      = 5;
   localparam int BIT_TRANSMIT_EMPTY    = 4;

   // ==========================================================
   // Reset values and counts
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic [3:0] LAST_BIT_EIGHT  = 4'h7;
   localparam logic [3:0] LAST_BIT_NINE   = 4'h8;
   localparam logic [1:0] FIFO_DEPTH      = 2'h2;
   localparam logic [1:0] RESET_SYNC_INIT = 2'h0;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_GAP    = 3'b100
   } usm_fsm_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } usm_bus_s;

   typedef struct packed {
      logic clk_out;
      logic clk_oe;
      logic data_out;
      logic data_oe;
   } usm_pins_s;

endpackage : usm_pkg

// file: usm_rx_fifo.sv
/*
   Two-entry receive store of nine-bit characters with a registered top.
   Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps

module usm_rx_fifo
   import usm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       flush,
   input  wire logic       push,
   input  wire logic [8:0] push_data,
   input  wire logic       pop,
   output logic [8:0]      top,
   output logic [1:0]      count
);

   typedef struct packed {
      logic [1:0][8:0] mem;
      logic            wptr;
      logic            rptr;
      logic [1:0]      count;
      logic [8:0]      top;
   } usm_fifo_s;

   usm_fifo_s fifo_reg;
   usm_fifo_s fifo_next;

   always_comb begin
      fifo_next = fifo_reg;
      if (flush) begin
         fifo_next = '0;
      end else begin
         if (push && fifo_reg.count < FIFO_DEPTH) begin
            fifo_next.mem[fifo_reg.wptr] = push_data;
            fifo_next.wptr               = ~fifo_reg.wptr;
         end
         if (pop && fifo_reg.count != 2'h0) begin
            fifo_next.rptr = ~fifo_reg.rptr;
         end
         fifo_next.count = 2'(fifo_reg.count
                           + {1'b0, push && fifo_reg.count < FIFO_DEPTH}
                           - {1'b0, pop && fifo_reg.count != 2'h0});
      end
      // Top is registered so the read port sees a flop, not a mux
      fifo_next.top = fifo_next.mem[fifo_next.rptr];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_reg <= '0;
      end else begin
         fifo_reg <= fifo_next;
      end
   end

   assign top   = fifo_reg.top;
   assign count = fifo_reg.count;

endmodule : usm_rx_fifo

// file: usm_port.sv
/*
   Clocked half-duplex serial port: master clock generation, slave clock
   edge detection, transmit holding and shifter, receive shifter and
   two-entry receive store behind a plain register port.
   Assumes clk at 100 MHz; both pins arrive from outside the clock domain.
*/
`timescale 1ns/1ps

// Function
// - Clocked mode, master by source bit, transmit when no receive enable, needs enable.
// - No start or stop bits; never transmit and receive together.
// - Master drives shift clock and enables clock pin driver when configured.
// - One clock per data bit, no extra clocks.
// - Transmit data changes on leading edge, held until next leading edge.
// - Polarity bit set idles high; clear idles low.
// - Holding write starts transfer; waits while shifter busy.
// - Master transmit drives data pin and clock pin.
// - Master receive releases the data pin driver.
// - Master single receive takes one character then clears itself.
// - Continuous receive clocks until cleared; clearing aborts partial character.
// - Both enables: single clears after first, continuous carries on.
// - Receive samples data on trailing clock edge into receive shifter.
// - Completed character enters two-entry store; flag while unread.
// - Slave takes clock from pin, driver off, one bit per clock.
// - Third character with store full sets overrun, blocks reception.
// - Overrun cleared by read in single mode, else by continuous or enable clear.
// - Nine-bit receive shifts nine bits; ninth bit shown for top entry.
// - Transmit empty flag shows holding register can take a character.
module usm_port
   import usm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire usm_bus_s   bus,
   output logic [7:0]      rdata,
   input  wire logic       clock_pin_in,
   input  wire logic       data_pin_in,
   output usm_pins_s       pins
);

   typedef struct packed {
      usm_fsm_e   fsm;
      logic [15:0] timer;
      logic [3:0] bit_cnt;
      logic [8:0] tx_shift;
      logic       tx_busy;
      logic [8:0] rx_shift;
      logic [8:0] holding;
      logic       holding_full;
      logic       overrun_flag;
      logic       clock_polarity;
      logic       wide_divisor_select;
      logic       port_enable;
      logic       nine_bit_receive;
      logic       single_receive_enable;
      logic       continuous_receive_enable;
      logic       clock_source_master;
      logic       nine_bit_transmit;
      logic       transmit_enable;
      logic       clocked_mode;
      logic       high_speed_select;
      logic [7:0] baud_divisor_low;
      logic [7:0] baud_divisor_high;
      logic       ck_s1;
      logic       ck_s2;
      logic       ck_s3;
      logic       dt_s1;
      logic       dt_s2;
      usm_pins_s  pins;
      logic [7:0] rdata;
   } usm_state_s;

   usm_state_s state_reg;
   usm_state_s state_next;

   logic [1:0] rst_sync_reg;
   logic       rst_n;
   logic [8:0] fifo_top;
   logic [1:0] fifo_count;
   logic       fifo_push;
   logic       fifo_pop;
   logic       fifo_flush;
   logic [8:0] rx_word;

   // ==========================================================
   // Reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_reg <= RESET_SYNC_INIT;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ==========================================================
   // Helpers
   function automatic logic [3:0] last_index(input logic nine);
      last_index = nine ? LAST_BIT_NINE : LAST_BIT_EIGHT;
   endfunction : last_index

   // ==========================================================
   // Receive store
   usm_rx_fifo u_rx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (fifo_flush),
      .push      (fifo_push),
      .push_data (rx_word),
      .pop       (fifo_pop),
      .top       (fifo_top),
      .count     (fifo_count)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic       run;
      logic       master;
      logic       rx_mode;
      logic       tx_mode;
      logic       rx_go;
      logic       tick;
      logic       lead_ev;
      logic       trail_ev;
      logic       ck_rise;
      logic       ck_fall;
      logic       sample;
      logic [15:0] divisor;
      logic       hold_wr;
      logic       fifo_rd;

      state_next = state_reg;
      fifo_push  = 1'b0;
      fifo_flush = 1'b0;
      lead_ev    = 1'b0;
      trail_ev   = 1'b0;
      tick       = 1'b0;
      rx_word    = state_reg.rx_shift;

      // Pins pass two flops before any logic looks at them
      state_next.ck_s1 = clock_pin_in;
      state_next.ck_s2 = state_reg.ck_s1;
      state_next.ck_s3 = state_reg.ck_s2;
      state_next.dt_s1 = data_pin_in;
      state_next.dt_s2 = state_reg.dt_s1;
      sample  = state_reg.dt_s2;
      ck_rise = state_reg.ck_s2 && !state_reg.ck_s3;
      ck_fall = !state_reg.ck_s2 && state_reg.ck_s3;

      hold_wr = bus.wr && bus.addr == ADDR_TRANSMIT_HOLDING;
      fifo_rd = bus.rd && bus.addr == ADDR_RECEIVE_FIFO_TOP;
      fifo_pop = fifo_rd && fifo_count != 2'h0;

      // ---------------- register writes
      if (bus.wr) begin
         unique case (bus.addr)
            ADDR_BAUD_CONTROL: begin
               state_next.clock_polarity      = bus.wdata[BIT_CLOCK_POLARITY];
               state_next.wide_divisor_select = bus.wdata[BIT_WIDE_DIVISOR];
            end
            ADDR_RECEIVE_STATUS: begin
               state_next.port_enable               = bus.wdata[BIT_PORT_ENABLE];
               state_next.nine_bit_receive          = bus.wdata[BIT_NINE_RECEIVE];
               state_next.single_receive_enable     = bus.wdata[BIT_SINGLE_RECEIVE];
               state_next.continuous_receive_enable = bus.wdata[BIT_CONTINUOUS];
            end
            ADDR_DIVISOR_LOW:  state_next.baud_divisor_low  = bus.wdata;
            ADDR_DIVISOR_HIGH: state_next.baud_divisor_high = bus.wdata;
            ADDR_TRANSMIT_STATUS: begin
               state_next.clock_source_master = bus.wdata[BIT_CLOCK_SOURCE];
               state_next.nine_bit_transmit   = bus.wdata[BIT_NINE_TRANSMIT];
               state_next.transmit_enable     = bus.wdata[BIT_TRANSMIT_ENABLE];
               state_next.clocked_mode        = bus.wdata[BIT_CLOCKED_MODE];
               state_next.high_speed_select   = bus.wdata[BIT_HIGH_SPEED];
               state_next.holding[8]          = bus.wdata[BIT_TRANSMIT_NINTH];
            end
            default: ;
         endcase
      end
      if (hold_wr) begin
         state_next.holding[7:0] = bus.wdata;
      end

      // ---------------- mode decode
      run     = state_reg.port_enable && state_reg.clocked_mode;
      master  = run && state_reg.clock_source_master;
      // Slave receive ignores the single enable
      rx_mode = master ? (state_reg.single_receive_enable
                          || state_reg.continuous_receive_enable)
                       : state_reg.continuous_receive_enable;
      tx_mode = !state_reg.single_receive_enable
                && !state_reg.continuous_receive_enable;
      rx_go   = run && rx_mode && !state_reg.overrun_flag;

      // ---------------- holding to shifter
      if (run && tx_mode && state_reg.transmit_enable
          && !state_reg.tx_busy && state_reg.holding_full) begin
         state_next.tx_shift     = state_reg.holding;
         state_next.tx_busy      = 1'b1;
         state_next.bit_cnt      = 4'h0;
         state_next.holding_full = 1'b0;
      end
      // A write in the same cycle as the transfer keeps the new character
      if (hold_wr) begin
         state_next.holding_full = 1'b1;
      end

      // ---------------- master clock generator
      divisor = state_reg.wide_divisor_select
                ? {state_reg.baud_divisor_high, state_reg.baud_divisor_low}
                : {8'h00, state_reg.baud_divisor_low};
      if (state_reg.timer >= divisor) begin
         tick = 1'b1;
         state_next.timer = 16'h0000;
      end else begin
         state_next.timer = 16'(state_reg.timer + 16'h0001);
      end
      unique case (state_reg.fsm)
         ST_IDLE: begin
            state_next.timer = 16'h0000;
            if (master && (state_reg.tx_busy || rx_go)) begin
               state_next.fsm = ST_ACTIVE;
               lead_ev        = 1'b1;
            end
         end
         ST_ACTIVE: begin
            if (tick) begin
               state_next.fsm = ST_GAP;
               trail_ev       = 1'b1;
            end
         end
         ST_GAP: begin
            if (tick) begin
               if (master && (state_reg.tx_busy || rx_go)) begin
                  state_next.fsm = ST_ACTIVE;
                  lead_ev        = 1'b1;
               end else begin
                  state_next.fsm = ST_IDLE;
               end
            end
         end
         default: state_next.fsm = ST_IDLE;
      endcase

      // ---------------- slave clock edges
      if (run && !state_reg.clock_source_master) begin
         lead_ev  = state_reg.clock_polarity ? ck_fall : ck_rise;
         trail_ev = state_reg.clock_polarity ? ck_rise : ck_fall;
      end

      // ---------------- shift engine
      if (state_reg.tx_busy) begin
         if (lead_ev) begin
            state_next.pins.data_out = state_reg.tx_shift[state_reg.bit_cnt];
         end
         if (trail_ev) begin
            if (state_reg.bit_cnt == last_index(state_reg.nine_bit_transmit)) begin
               state_next.tx_busy = 1'b0;
               state_next.bit_cnt = 4'h0;
            end else begin
               state_next.bit_cnt = 4'(state_reg.bit_cnt + 4'h1);
            end
         end
      end else if (rx_go && trail_ev) begin
         rx_word[state_reg.bit_cnt] = sample;
         state_next.rx_shift        = rx_word;
         if (state_reg.bit_cnt == last_index(state_reg.nine_bit_receive)) begin
            state_next.bit_cnt  = 4'h0;
            state_next.rx_shift = 9'h000;
            if (fifo_count == FIFO_DEPTH) begin
               state_next.overrun_flag = 1'b1;
            end else begin
               fifo_push = 1'b1;
            end
            // Software writing the bit in this cycle keeps its value
            if (!(bus.wr && bus.addr == ADDR_RECEIVE_STATUS)) begin
               state_next.single_receive_enable = 1'b0;
            end
         end else begin
            state_next.bit_cnt = 4'(state_reg.bit_cnt + 4'h1);
         end
      end else if (!state_reg.tx_busy && !rx_go) begin
         // Receive enables dropped: partial character is thrown away
         state_next.bit_cnt  = 4'h0;
         state_next.rx_shift = 9'h000;
         if (master && !state_next.tx_busy && state_reg.fsm != ST_IDLE) begin
            state_next.fsm = ST_IDLE;
         end
      end

      // ---------------- overrun release
      if (state_reg.overrun_flag) begin
         if (fifo_rd && !state_reg.continuous_receive_enable) begin
            state_next.overrun_flag = 1'b0;
         end
         if (!state_next.continuous_receive_enable
             && state_reg.continuous_receive_enable) begin
            state_next.overrun_flag = 1'b0;
         end
      end

      // ---------------- port disabled
      if (!state_reg.port_enable) begin
         state_next.fsm          = ST_IDLE;
         state_next.bit_cnt      = 4'h0;
         state_next.tx_busy      = 1'b0;
         state_next.rx_shift     = 9'h000;
         state_next.overrun_flag = 1'b0;
         fifo_flush              = 1'b1;
         fifo_push               = 1'b0;
      end

      // ---------------- pin drivers
      state_next.pins.clk_oe  = master && (state_reg.transmit_enable || rx_mode);
      state_next.pins.clk_out = (state_next.fsm == ST_ACTIVE)
                                ^ state_reg.clock_polarity;
      state_next.pins.data_oe = run && tx_mode
                                && state_reg.transmit_enable;
      if (!state_next.pins.data_oe) begin
         state_next.pins.data_out = 1'b0;
      end

      // ---------------- register reads, data one cycle later
      state_next.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_BAUD_CONTROL: begin
               state_next.rdata[BIT_RECEIVE_IDLE]   = !(rx_go && state_reg.fsm != ST_IDLE);
               state_next.rdata[BIT_CLOCK_POLARITY] = state_reg.clock_polarity;
               state_next.rdata[BIT_WIDE_DIVISOR]   = state_reg.wide_divisor_select;
            end
            ADDR_RECEIVE_STATUS: begin
               state_next.rdata[BIT_PORT_ENABLE]    = state_reg.port_enable;
               state_next.rdata[BIT_NINE_RECEIVE]   = state_reg.nine_bit_receive;
               state_next.rdata[BIT_SINGLE_RECEIVE] = state_reg.single_receive_enable;
               state_next.rdata[BIT_CONTINUOUS]     = state_reg.continuous_receive_enable;
               state_next.rdata[BIT_OVERRUN]        = state_reg.overrun_flag;
               state_next.rdata[BIT_RECEIVE_NINTH]  = fifo_top[8];
            end
            ADDR_DIVISOR_LOW:  state_next.rdata = state_reg.baud_divisor_low;
            ADDR_DIVISOR_HIGH: state_next.rdata = state_reg.baud_divisor_high;
            ADDR_TRANSMIT_STATUS: begin
               state_next.rdata[BIT_CLOCK_SOURCE]    = state_reg.clock_source_master;
               state_next.rdata[BIT_NINE_TRANSMIT]   = state_reg.nine_bit_transmit;
               state_next.rdata[BIT_TRANSMIT_ENABLE] = state_reg.transmit_enable;
               state_next.rdata[BIT_CLOCKED_MODE]    = state_reg.clocked_mode;
               state_next.rdata[BIT_HIGH_SPEED]      = state_reg.high_speed_select;
               state_next.rdata[BIT_SHIFTER_EMPTY]   = !state_reg.tx_busy;
               state_next.rdata[BIT_TRANSMIT_NINTH]  = state_reg.holding[8];
            end
            ADDR_RECEIVE_FIFO_TOP: begin
               if (fifo_count != 2'h0) begin
                  state_next.rdata = fifo_top[7:0];
               end
            end
            ADDR_FLAGS: begin
               state_next.rdata[BIT_RECEIVE_FLAG]   = fifo_count != 2'h0;
               state_next.rdata[BIT_TRANSMIT_EMPTY] = !state_reg.holding_full;
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= '0;
         state_reg.fsm <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign pins  = state_reg.pins;

endmodule : usm_port

// file: usm_port_monitor.sv
/* Concurrent checks on the serial port's register port and pins.
   Bound to usm_port by the bench; sees its ports only. */
`timescale 1ns/1ps
module usm_port_monitor
   import usm_pkg::*;
(
   input wire logic       clk,
   input wire logic       nrst,
   input wire usm_bus_s   bus,
   input wire logic [7:0] rdata,
   input wire logic       clock_pin_in,
   input wire logic       data_pin_in,
   input wire usm_pins_s  pins
);
   logic       pol_q;
   logic [7:0] txs_q;
   logic       cfg_w;
   // Shadows of polarity and transmit control, taken from the writes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pol_q <= 1'b0;
         txs_q <= 8'h00;
      end else if (bus.wr) begin
         if (bus.addr == ADDR_BAUD_CONTROL) pol_q <= bus.wdata[BIT_CLOCK_POLARITY];
         if (bus.addr == ADDR_TRANSMIT_STATUS) txs_q <= bus.wdata;
      end
   end
   assign cfg_w = bus.wr && bus.addr == ADDR_RECEIVE_STATUS;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ====================================
   // Assertions
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data outside answer cycle");
   a_holding_wo: assert property (
      $past(bus.rd) && $past(bus.addr) == ADDR_TRANSMIT_HOLDING |-> rdata == 8'h00)
      else $error("holding register read back nonzero");
   a_quiet_data: assert property (!pins.data_oe |-> !pins.data_out)
      else $error("data driven while released");
   a_data_lead: assert property (
      pins.data_oe && $past(pins.data_oe) && $changed(pins.data_out)
      |-> $changed(pins.clk_out) && pins.clk_out != pol_q)
      else $error("data changed off a leading clock edge");
   a_rx_release: assert property (
      cfg_w && (bus.wdata[BIT_SINGLE_RECEIVE] || bus.wdata[BIT_CONTINUOUS])
      |-> ##[1:3] !pins.data_oe) else $error("data pin kept in receive");
   a_clk_drive: assert property (
      cfg_w && bus.wdata[BIT_PORT_ENABLE] && txs_q[BIT_CLOCK_SOURCE]
      && txs_q[BIT_CLOCKED_MODE] && (txs_q[BIT_TRANSMIT_ENABLE]
      || bus.wdata[BIT_SINGLE_RECEIVE] || bus.wdata[BIT_CONTINUOUS])
      |-> ##[1:3] pins.clk_oe) else $error("clock pin not driven");
   a_disable_off: assert property (
      cfg_w && !bus.wdata[BIT_PORT_ENABLE] |-> ##[1:3] !pins.clk_oe && !pins.data_oe)
      else $error("pins held after disable");
   a_rx_abort: assert property (
      cfg_w && bus.wdata[BIT_PORT_ENABLE] && !txs_q[BIT_TRANSMIT_ENABLE]
      && !bus.wdata[BIT_SINGLE_RECEIVE] && !bus.wdata[BIT_CONTINUOUS]
      |-> ##5 (pins.clk_out == pol_q)[*4]) else $error("clock ran after receive stop");
endmodule : usm_port_monitor

// file: usm_slave_model.sv
/* Slave device on the clock and data lines.
   Assumes the bench resolves both wires and lowers go between tests. */
`timescale 1ns/1ps
module usm_slave_model (
   input  wire logic       ck,
   input  wire logic       dt,
   input  wire logic       pol,
   input  wire logic       go,
   input  wire logic [8:0] word,
   input  wire logic [3:0] nbits,
   output logic            dq,
   output logic [7:0]      cap,
   output int              edges,
   output int              nchar
);
   int idx;
   initial begin
      dq = 1'b0;
      cap = 8'h00;
      edges = 0;
      nchar = 0;
      idx = 0;
   end
   always @(posedge ck or negedge ck or negedge go) begin
      if (!go) begin
         // Released: keep moving so a stale bit never passes
         dq = ~dq;
         idx = 0;
         edges = 0;
      end else if (ck !== pol) begin
         dq = word[idx];
         idx = (idx + 1) % nbits;
      end else begin
         cap = {dt, cap[7:1]};
         edges++;
         if (edges % nbits == 0) nchar++;
      end
   end
endmodule : usm_slave_model

// file: test_usm_port.sv
/* Self-checking bench of usm_port as master against usm_slave_model.
   Assumes the package, the port, the slave model and the monitor. */
`timescale 1ns/1ps
module test_usm_port
   import usm_pkg::*;
;
   logic        clk, nrst, pol, go, ck, dt, dq;
   logic        rd_q = 1'b0;
   usm_bus_s    bus;
   usm_pins_s   pins;
   logic [7:0]  rdata, cap;
   logic [8:0]  word;
   logic [3:0]  nbits;
   logic [31:0] seed;
   logic [10:0] e;
   logic [10:0] expq[$];
   logic [7:0]  txq[$];
   int          n_mismatch, comparisons, edges, nchar, nchar_q;
   assign ck = pins.clk_oe ? pins.clk_out : pol;
   assign dt = pins.data_oe ? pins.data_out : dq;
   usm_port i_usm_port (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
      .clock_pin_in(ck), .data_pin_in(dt), .pins(pins));
   usm_slave_model i_usm_slave_model (.ck(ck), .dt(dt), .pol(pol), .go(go), .word(word),
      .nbits(nbits), .dq(dq), .cap(cap), .edges(edges), .nchar(nchar));
   always #5 clk = ~clk;
   // ====================================
   // Tasks
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      bus <= '0;
   endtask : acc
   task automatic rd(input logic [2:0] a, input logic [7:0] x);
      expq.push_back({a, x});
      acc(1'b0, a, 8'h00);
   endtask : rd
   task automatic wait_edges(input int n);
      for (int i = 0; i < 3000 && edges < n; i++) @(posedge clk);
      repeat (20) @(posedge clk);
   endtask : wait_edges
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // Results come back in order of request
   always @(posedge clk) begin
      if (rd_q) begin
         e = expq.pop_front();
         chk($sformatf("reg %0d", e[10:8]), {1'b0, rdata}, {1'b0, e[7:0]});
      end
      if (nchar != nchar_q && txq.size() > 0)
         chk("serial byte", {1'b0, cap}, {1'b0, txq.pop_front()});
      rd_q <= bus.rd;
      nchar_q <= nchar;
   end
   initial begin
      #150000;
      n_mismatch++;
      end_sim;
   end
   // ====================================
   // Main sequence
   initial begin
      clk = 1'b0; nrst = 1'b0; bus = '0; pol = 1'b0; go = 1'b0;
      word = 9'h000; nbits = 4'h8; seed = 32'h417f9b94; nchar_q = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      seed = lfsr(seed);
      acc(1'b1, ADDR_DIVISOR_HIGH, seed[7:0]);
      rd(ADDR_DIVISOR_HIGH, seed[7:0]);
      acc(1'b1, ADDR_DIVISOR_LOW, 8'h03);
      rd(ADDR_DIVISOR_LOW, 8'h03);
      rd(ADDR_TRANSMIT_HOLDING, 8'h00);
      $display("test registers done");
      for (int p = 0; p < 2; p++) begin
         go <= 1'b0;
         pol <= p[0];
         nbits <= 4'(8 + p);
         acc(1'b1, ADDR_BAUD_CONTROL, {3'h0, p[0], 4'h0});
         acc(1'b1, ADDR_TRANSMIT_STATUS, {1'b1, p[0], 5'h18, p[0]});
         acc(1'b1, ADDR_RECEIVE_STATUS, 8'h80);
         go <= 1'b1;
         seed = lfsr(seed);
         txq.push_back(p[0] ? {1'b1, seed[7:1]} : seed[7:0]);
         txq.push_back(p[0] ? {1'b1, seed[15:9]} : seed[15:8]);
         acc(1'b1, ADDR_TRANSMIT_HOLDING, seed[7:0]);
         acc(1'b1, ADDR_TRANSMIT_HOLDING, seed[15:8]);
         rd(ADDR_FLAGS, 8'h00);
         wait_edges(16 + 2 * p);
         chk("clock count", edges[8:0], p[0] ? 9'h012 : 9'h010);
         rd(ADDR_FLAGS, 8'h10);
         rd(ADDR_TRANSMIT_STATUS, {1'b1, p[0], 5'h19, p[0]});
         acc(1'b1, ADDR_RECEIVE_STATUS, 8'h00);
      end
      $display("test transmit done");
      acc(1'b1, ADDR_TRANSMIT_STATUS, 8'h90);
      for (int n = 8; n < 10; n++) begin
         go <= 1'b0;
         nbits <= n[3:0];
         seed = lfsr(seed);
         word <= seed[8:0];
         acc(1'b1, ADDR_RECEIVE_STATUS, {1'b1, n[0], 6'h20});
         go <= 1'b1;
         wait_edges(n);
         chk("clock count", edges[8:0], n[8:0]);
         rd(ADDR_RECEIVE_STATUS, {1'b1, n[0], 5'h00, n[0] & seed[8]});
         rd(ADDR_FLAGS, 8'h30);
         rd(ADDR_RECEIVE_FIFO_TOP, seed[7:0]);
      end
      go <= 1'b0;
      nbits <= 4'h8;
      acc(1'b1, ADDR_RECEIVE_STATUS, 8'h90);
      go <= 1'b1;
      wait_edges(24);
      rd(ADDR_RECEIVE_STATUS, 8'h92);
      acc(1'b1, ADDR_RECEIVE_STATUS, 8'h80);
      rd(ADDR_RECEIVE_STATUS, 8'h80);
      rd(ADDR_RECEIVE_FIFO_TOP, word[7:0]);
      rd(ADDR_RECEIVE_FIFO_TOP, word[7:0]);
      rd(ADDR_FLAGS, 8'h10);
      rd(ADDR_RECEIVE_FIFO_TOP, 8'h00);
      acc(1'b1, ADDR_RECEIVE_STATUS, 8'h00);
      $display("test receive done");
      repeat (3) @(posedge clk);
      end_sim;
   end
endmodule : test_usm_port

bind usm_port usm_port_monitor i_usm_port_monitor (.clk(clk), .nrst(nrst), .bus(bus),
   .rdata(rdata), .clock_pin_in(clock_pin_in), .data_pin_in(data_pin_in), .pins(pins));
